// file: hw/stc_compare.sv
// comparator a, comparator p and the duty comparisons of the timer counter
module stc_compare (
  input wire logic [15:0] cnt,
  input wire logic [15:0] compare_a_value,
  input wire logic [7:0] period_compare_bits,
  output stc_pkg::stc_cmp_t cmp
);

  always_comb begin
    cmp.inc = cnt + 16'h0001;
    // matches look at the next count so that the clear lands exactly on the period
    cmp.match_a = (cmp.inc == compare_a_value);
    // only the high byte takes part; a zero period hits on the wrap to zero
    cmp.match_p = (cmp.inc[7:0] == 8'h00) && (cmp.inc[15:8] == period_compare_bits);
    cmp.duty_a = (cnt < compare_a_value);
    cmp.duty_p = (period_compare_bits == 8'h00) || (cnt[15:8] < period_compare_bits);
  end

endmodule // stc_compare

// file: hw/stc_out_stage.sv
// level, polarity and enable of the timer output pin for each mode
module stc_out_stage (
  input stc_pkg::stc_ctrl1_t ctrl,
  input wire logic cmp_level,
  input wire logic pwm_on,
  input wire logic pulse_on,
  output logic pin_level,
  output logic pin_en
);

  logic raw;

  always_comb begin
    raw = 1'b0;
    pin_en = 1'b0;
    case (ctrl.mode_select)
      stc_pkg::MODE_COMPARE: begin
        raw = cmp_level;
        pin_en = 1'b1;
      end
      stc_pkg::MODE_PWM: begin
        pin_en = 1'b1;
        // active level follows the initial-level bit here
        case (ctrl.pin_function)
          stc_pkg::PF_INACTIVE: raw = ~ctrl.output_initial_level;
          stc_pkg::PF_ACTIVE: raw = ctrl.output_initial_level;
          stc_pkg::PF_PWM: raw = pwm_on ? ctrl.output_initial_level
                                        : ~ctrl.output_initial_level;
          default: raw = pulse_on ? ctrl.output_initial_level
                                  : ~ctrl.output_initial_level;
        endcase
      end
      default: begin
        // timer/counter and capture leave the pin undriven and ignore oc and pol
        raw = 1'b0;
        pin_en = 1'b0;
      end
    endcase
    pin_level = pin_en ? (raw ^ ctrl.output_polarity_invert) : 1'b0;
  end

endmodule // stc_out_stage

// file: hw/stc_pkg.sv
// shared constants, register map and carrier types of the standard timer block
package stc_pkg;

  // register byte offsets on the avalon slave, one aligned word each
  localparam logic [4:0] OFS_CTRL0 = 5'h00;
  localparam logic [4:0] OFS_CTRL1 = 5'h04;
  localparam logic [4:0] OFS_COUNT = 5'h08;
  localparam logic [4:0] OFS_CMPA = 5'h0C;
  localparam logic [4:0] OFS_PERIOD = 5'h10;
  localparam logic [4:0] OFS_FLAGS = 5'h14;

  // field positions
  localparam int unsigned ON_BIT = 3;
  localparam int unsigned FLAG_A_BIT = 0;
  localparam int unsigned FLAG_P_BIT = 1;

  // mode field encodings
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;

  // pin function encodings, compare-match output mode
  localparam logic [1:0] FN_NONE = 2'h0;
  localparam logic [1:0] FN_LOW = 2'h1;
  localparam logic [1:0] FN_HIGH = 2'h2;
  localparam logic [1:0] FN_TOGGLE = 2'h3;

  // pin function encodings, pwm / single-pulse mode
  localparam logic [1:0] PF_INACTIVE = 2'h0;
  localparam logic [1:0] PF_ACTIVE = 2'h1;
  localparam logic [1:0] PF_PWM = 2'h2;
  localparam logic [1:0] PF_PULSE = 2'h3;

  // values after reset
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [15:0] CMPA_RST = 16'h0000;
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // control register one, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] mode_select;
    logic [1:0] pin_function;
    logic output_initial_level;
    logic output_polarity_invert;
    logic duty_period_swap;
    logic clear_source_select;
  } stc_ctrl1_t;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } stc_av_req_t;

  typedef struct packed {
    logic [15:0] inc;
    logic match_a;
    logic match_p;
    logic duty_a;
    logic duty_p;
  } stc_cmp_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } stc_bus_st_t;

endpackage

// file: hw/stc_timer.sv
// standard timer: counter, clear select, comparators, flags, output pin, avalon slave
module stc_timer (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic timer_output_pin,
  output logic timer_output_pin_oe,
  output logic match_a_flag,
  output logic match_p_flag
);

  typedef struct packed {
    stc_pkg::stc_bus_st_t bus_st;
    logic waitrequest;
    logic [31:0] readdata;
    stc_pkg::stc_ctrl1_t ctrl1;
    logic timer_on_bit;
    logic on_prev;
    logic [15:0] cnt;
    logic [15:0] compare_a_value;
    logic [7:0] period_compare;
    logic flag_a;
    logic flag_p;
    logic cmp_level;
    logic pin_out;
    logic pin_oe;
  } stc_state_t;

  stc_state_t s_r;
  stc_state_t s_nxt;
  stc_pkg::stc_av_req_t req;
  stc_pkg::stc_cmp_t cm;
  logic pin_level;
  logic pin_en;
  logic pwm_on;

  // merge write data into a word lane by lane
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign req.address = avs_address;
  assign req.read = avs_read;
  assign req.write = avs_write;
  assign req.writedata = avs_writedata;
  assign req.byteenable = avs_byteenable;

  stc_compare u_compare (
    .cnt(s_r.cnt),
    .compare_a_value(s_r.compare_a_value),
    .period_compare_bits(s_r.period_compare),
    .cmp(cm)
  );

  // swap bit chooses which register sets the duty
  assign pwm_on = s_r.ctrl1.duty_period_swap ? cm.duty_p : cm.duty_a;

  stc_out_stage u_out_stage (
    .ctrl(s_r.ctrl1),
    .cmp_level(s_r.cmp_level),
    .pwm_on(pwm_on),
    .pulse_on(s_r.timer_on_bit),
    .pin_level(pin_level),
    .pin_en(pin_en)
  );

  always_comb begin
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic on_rise;
    logic cmp_family;
    logic is_pwm;
    logic is_pulse;
    logic clr_by_a;
    logic period_hit;
    logic set_a;
    logic set_p;
    logic clr_a;
    logic clr_p;
    logic do_write;

    rd_word = 32'h0000_0000;
    wr_word = 32'h0000_0000;
    on_rise = 1'b0;
    cmp_family = 1'b0;
    is_pwm = 1'b0;
    is_pulse = 1'b0;
    clr_by_a = 1'b0;
    period_hit = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    clr_a = 1'b0;
    clr_p = 1'b0;
    do_write = 1'b0;
    s_nxt = s_r;

    // mode decode
    cmp_family = (s_r.ctrl1.mode_select == stc_pkg::MODE_COMPARE)
              || (s_r.ctrl1.mode_select == stc_pkg::MODE_TIMER);
    is_pwm = (s_r.ctrl1.mode_select == stc_pkg::MODE_PWM);
    is_pulse = is_pwm && (s_r.ctrl1.pin_function == stc_pkg::PF_PULSE);

    // counter and comparators
    on_rise = s_r.timer_on_bit && !s_r.on_prev;
    s_nxt.on_prev = s_r.timer_on_bit;
    if (on_rise) begin
      s_nxt.cnt = stc_pkg::COUNT_RST;
      s_nxt.cmp_level = s_r.ctrl1.output_initial_level;
    end else if (s_r.timer_on_bit) begin
      // clear select only counts in compare and timer/counter modes
      clr_by_a = cmp_family && s_r.ctrl1.clear_source_select;
      if (clr_by_a) begin
        period_hit = cm.match_a;
      end else if (is_pulse) begin
        period_hit = 1'b0;
      end else if (is_pwm && s_r.ctrl1.duty_period_swap) begin
        period_hit = cm.match_a;
      end else begin
        period_hit = cm.match_p;
      end
      s_nxt.cnt = period_hit ? 16'h0000 : cm.inc;
      set_a = cm.match_a;
      set_p = cm.match_p && !clr_by_a && !is_pulse;
      if (is_pulse && cm.match_a) begin
        // a match ends the single pulse by switching the timer off
        s_nxt.timer_on_bit = 1'b0;
      end
      // only the a match moves the compare-mode pin level
      if (cm.match_a) begin
        case (s_r.ctrl1.pin_function)
          stc_pkg::FN_LOW: s_nxt.cmp_level = 1'b0;
          stc_pkg::FN_HIGH: s_nxt.cmp_level = 1'b1;
          stc_pkg::FN_TOGGLE: s_nxt.cmp_level = ~s_r.cmp_level;
          default: s_nxt.cmp_level = s_r.cmp_level;
        endcase
      end
    end

    // pin follows the internal level one clock later
    s_nxt.pin_out = pin_level;
    s_nxt.pin_oe = pin_en;

    // read mux
    case (s_r.bus_st == stc_pkg::BUS_IDLE ? req.address : 5'h1F)
      stc_pkg::OFS_CTRL0: rd_word[stc_pkg::ON_BIT] = s_r.timer_on_bit;
      stc_pkg::OFS_CTRL1: rd_word[7:0] = s_r.ctrl1;
      stc_pkg::OFS_COUNT: rd_word[15:0] = s_r.cnt;
      stc_pkg::OFS_CMPA: rd_word[15:0] = s_r.compare_a_value;
      stc_pkg::OFS_PERIOD: rd_word[7:0] = s_r.period_compare;
      stc_pkg::OFS_FLAGS: begin
        rd_word[stc_pkg::FLAG_A_BIT] = s_r.flag_a;
        rd_word[stc_pkg::FLAG_P_BIT] = s_r.flag_p;
      end
      default: rd_word = 32'h0000_0000;
    endcase

    // bus handshake: one idle cycle latches, the answer cycle commits
    case (s_r.bus_st)
      stc_pkg::BUS_IDLE: begin
        s_nxt.waitrequest = 1'b1;
        if (req.read || req.write) begin
          s_nxt.bus_st = stc_pkg::BUS_ANSWER;
          s_nxt.waitrequest = 1'b0;
          s_nxt.readdata = req.read ? rd_word : 32'h0000_0000;
        end
      end
      stc_pkg::BUS_ANSWER: begin
        s_nxt.bus_st = stc_pkg::BUS_IDLE;
        s_nxt.waitrequest = 1'b1;
        do_write = req.write;
      end
      default: begin
        s_nxt.bus_st = stc_pkg::BUS_IDLE;
        s_nxt.waitrequest = 1'b1;
      end
    endcase

    // register writes; a software write of the on bit wins over the pulse end
    if (do_write) begin
      case (req.address)
        stc_pkg::OFS_CTRL0: begin
          wr_word = lane_merge({28'h0000000, s_r.timer_on_bit, 3'h0},
                               req.writedata, req.byteenable);
          s_nxt.timer_on_bit = wr_word[stc_pkg::ON_BIT];
        end
        stc_pkg::OFS_CTRL1: begin
          wr_word = lane_merge({24'h000000, s_r.ctrl1}, req.writedata, req.byteenable);
          s_nxt.ctrl1 = wr_word[7:0];
        end
        stc_pkg::OFS_CMPA: begin
          // zero is not a legal compare value in compare mode; software avoids it
          wr_word = lane_merge({16'h0000, s_r.compare_a_value},
                               req.writedata, req.byteenable);
          s_nxt.compare_a_value = wr_word[15:0];
        end
        stc_pkg::OFS_PERIOD: begin
          wr_word = lane_merge({24'h000000, s_r.period_compare},
                               req.writedata, req.byteenable);
          s_nxt.period_compare = wr_word[7:0];
        end
        stc_pkg::OFS_FLAGS: begin
          if (req.byteenable[0]) begin
            clr_a = req.writedata[stc_pkg::FLAG_A_BIT];
            clr_p = req.writedata[stc_pkg::FLAG_P_BIT];
          end
        end
        default: wr_word = 32'h0000_0000;
      endcase
    end

    // sticky flags, write one to clear, a new event beats the clear
    s_nxt.flag_a = set_a || (s_r.flag_a && !clr_a);
    s_nxt.flag_p = set_p || (s_r.flag_p && !clr_p);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_r.bus_st <= stc_pkg::BUS_IDLE;
      s_r.waitrequest <= 1'b1;
      s_r.readdata <= 32'h0000_0000;
      s_r.ctrl1 <= stc_pkg::CTRL1_RST;
      s_r.timer_on_bit <= 1'b0;
      s_r.on_prev <= 1'b0;
      s_r.cnt <= stc_pkg::COUNT_RST;
      s_r.compare_a_value <= stc_pkg::CMPA_RST;
      s_r.period_compare <= stc_pkg::PERIOD_RST;
      s_r.flag_a <= 1'b0;
      s_r.flag_p <= 1'b0;
      s_r.cmp_level <= 1'b0;
      s_r.pin_out <= 1'b0;
      s_r.pin_oe <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.readdata;
  assign avs_waitrequest = s_r.waitrequest;
  assign timer_output_pin = s_r.pin_out;
  assign timer_output_pin_oe = s_r.pin_oe;
  assign match_a_flag = s_r.flag_a;
  assign match_p_flag = s_r.flag_p;

endmodule // stc_timer

// file: verif/stc_timer_bench.sv
// self-checking bench of the standard timer: registers, compare output and clearing
module stc_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic timer_output_pin;
  logic timer_output_pin_oe;
  logic match_a_flag;
  logic match_p_flag;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  logic [31:0] r;
  logic e;
  stc_pkg::stc_ctrl1_t c1;

  stc_timer uut (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer_output_pin,
    .timer_output_pin_oe, .match_a_flag, .match_p_flag);

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // read data are checked here, against the oldest note in the queue
  always @(posedge ref_clk) begin
    cyc++;
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
    if (cyc == 98000) begin
      bad_count++;
      final_report();
    end
  end

  // the global cycle ceiling bounds this wait
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h00000000);
  endtask

  // compare a is never zero here, the mode forbids it
  task automatic start(input logic [7:0] c, input logic [15:0] a, input logic [7:0] p);
    bus(1'b1, stc_pkg::OFS_CTRL0, 32'h0);
    bus(1'b1, stc_pkg::OFS_CTRL1, {24'h0, c});
    bus(1'b1, stc_pkg::OFS_CMPA, {16'h0, a});
    bus(1'b1, stc_pkg::OFS_PERIOD, {24'h0, p});
    bus(1'b1, stc_pkg::OFS_FLAGS, 32'h3);
    bus(1'b1, stc_pkg::OFS_CTRL0, 32'h8);
  endtask

  task automatic gap(output int k);
    logic p;
    repeat (4) @(posedge ref_clk);
    p = timer_output_pin;
    do @(posedge ref_clk); while (timer_output_pin === p);
    p = timer_output_pin;
    k = 0;
    do begin @(posedge ref_clk); k++; end while (timer_output_pin === p);
  endtask

  task automatic wait_a();
    while (match_a_flag !== 1'b1) @(posedge ref_clk);
  endtask

  initial begin
    void'($urandom(32'h19E93AF4));
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 7; k++) rd(5'(k * 4), 32'h0);
    // bit 0 forced so compare a never holds the forbidden zero
    r = $urandom | 32'h1;
    bus(1'b1, stc_pkg::OFS_CMPA, r);
    rd(stc_pkg::OFS_CMPA, {16'h0, r[15:0]});
    avs_byteenable <= 4'h2;
    bus(1'b1, stc_pkg::OFS_CMPA, ~r);
    avs_byteenable <= 4'hF;
    rd(stc_pkg::OFS_CMPA, {16'h0, ~r[15:8], r[7:0]});
    bus(1'b1, stc_pkg::OFS_PERIOD, r);
    rd(stc_pkg::OFS_PERIOD, {24'h0, r[7:0]});
    bus(1'b1, stc_pkg::OFS_COUNT, r);
    rd(stc_pkg::OFS_COUNT, 32'h0);
    bus(1'b1, 5'h18, r);
    rd(5'h18, 32'h0);
    bus(1'b1, stc_pkg::OFS_CTRL1, r);
    rd(stc_pkg::OFS_CTRL1, {24'h0, r[7:0]});
    // every pin function, both initial levels, random polarity; period below compare a
    for (int k = 0; k < 8; k++) begin
      c1 = 8'h01;
      c1.pin_function = 2'(k >> 1);
      c1.output_initial_level = k[0];
      c1.output_polarity_invert = 1'($urandom);
      start(c1, 16'h0300, 8'h01);
      repeat (3) @(posedge ref_clk);
      e = c1.output_initial_level;
      chk(timer_output_pin, e ^ c1.output_polarity_invert);
      if (c1.pin_function == stc_pkg::FN_TOGGLE) e = ~e;
      else if (c1.pin_function != stc_pkg::FN_NONE) e = c1.pin_function[1];
      wait_a();
      repeat (2) @(posedge ref_clk);
      chk(timer_output_pin, e ^ c1.output_polarity_invert);
      chk(match_p_flag, 32'h0);
    end
    start(8'hFD, 16'h0300, 8'h01);
    wait_a();
    chk(timer_output_pin, 32'h0);
    chk(timer_output_pin_oe, 32'h0);
    start(8'h98, 16'h0010, 8'h01);
    repeat (4) @(posedge ref_clk);
    chk(timer_output_pin, 32'h1);
    chk(timer_output_pin_oe, 32'h1);
    start(8'h8C, 16'h0010, 8'h01);
    repeat (4) @(posedge ref_clk);
    chk(timer_output_pin, 32'h1);
    // pwm with clear select set: the low phase shows which register sets the period
    start(8'hA9, 16'h0040, 8'h01);
    gap(n);
    chk(n, 32'd192);
    start(8'hAB, 16'h0300, 8'h01);
    gap(n);
    chk(n, 32'd512);
    // single pulse: active while on, a match ends it and drops the on bit
    start(8'hB8, 16'h0020, 8'h01);
    repeat (4) @(posedge ref_clk);
    chk(timer_output_pin, 32'h1);
    wait_a();
    repeat (2) @(posedge ref_clk);
    chk(timer_output_pin, 32'h0);
    rd(stc_pkg::OFS_CTRL0, 32'h0);
    // capture mode still clears on the period match although clear select is set
    start(8'h41, 16'h0010, 8'h01);
    repeat (300) @(posedge ref_clk);
    chk(match_p_flag, 32'h1);
    chk(timer_output_pin_oe, 32'h0);
    // stopped two counts after the restart, twice: value kept, and cleared on the rise
    start(8'h01, 16'h0100, 8'h01);
    bus(1'b1, stc_pkg::OFS_CTRL0, 32'h0);
    rd(stc_pkg::OFS_COUNT, 32'h2);
    bus(1'b1, stc_pkg::OFS_CTRL0, 32'h8);
    bus(1'b1, stc_pkg::OFS_CTRL0, 32'h0);
    rd(stc_pkg::OFS_COUNT, 32'h2);
    start(8'h30, 16'h0010, 8'h01);
    gap(n);
    chk(n, 32'd256);
    chk(match_p_flag, 32'h1);
    chk(match_a_flag, 32'h1);
    start(8'h30, 16'h0010, 8'h00);
    gap(n);
    chk(n, 32'd65536);
    final_report();
  end
endmodule // stc_timer_bench

// file: verif/stc_timer_chk.sv
// port assertions of the standard timer, with a snooped copy of the control bits
module stc_timer_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_oe,
  input wire logic match_a_flag,
  input wire logic match_p_flag
);
  typedef struct packed {
    stc_pkg::stc_ctrl1_t c1;
    logic on;
    logic [2:0] quiet;
  } stc_shadow_t;
  stc_shadow_t sh_r;
  stc_shadow_t sh_nxt;
  logic cmt;
  logic start;
  logic cmp_mode;
  assign cmt = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign start = cmt && avs_address == stc_pkg::OFS_CTRL0 && avs_writedata[3] && !sh_r.on;
  assign cmp_mode = sh_r.c1.mode_select == stc_pkg::MODE_COMPARE;
  // quiet counts cycles since the last control write, so pin settling is excused
  always_comb begin
    sh_nxt = sh_r;
    if (sh_r.quiet != 3'h7) sh_nxt.quiet = sh_r.quiet + 3'h1;
    if (cmt && avs_address == stc_pkg::OFS_CTRL0) begin
      sh_nxt.on = avs_writedata[3];
      sh_nxt.quiet = 3'h0;
    end
    if (cmt && avs_address == stc_pkg::OFS_CTRL1) begin
      sh_nxt.c1 = avs_writedata[7:0];
      sh_nxt.quiet = 3'h0;
    end
    if (!rstn) sh_nxt = 12'h000;
  end
  always_ff @(posedge ref_clk) begin
    sh_r <= sh_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_ctrl_readback: assert property (avs_read && !avs_waitrequest
    && avs_address == stc_pkg::OFS_CTRL1 |-> avs_readdata == {24'h000000, sh_r.c1})
    else $error("control readback differs from last write");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 5'h14
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  a_flag_a_kept: assert property (
    match_a_flag && !(cmt && avs_address == stc_pkg::OFS_FLAGS && avs_writedata[0])
    |=> match_a_flag) else $error("flag a dropped without a clear");
  a_flag_p_kept: assert property (
    match_p_flag && !(cmt && avs_address == stc_pkg::OFS_FLAGS && avs_writedata[1])
    |=> match_p_flag) else $error("flag p dropped without a clear");
  a_pin_initial: assert property (start && cmp_mode |-> ##3
    timer_output_pin == (sh_r.c1.output_initial_level ^ sh_r.c1.output_polarity_invert))
    else $error("pin not at initial level after start");
  a_fn_none_hold: assert property (cmp_mode && sh_r.c1.pin_function == stc_pkg::FN_NONE
    && sh_r.on && sh_r.quiet >= 3'h4 |-> $stable(timer_output_pin))
    else $error("pin moved with no-change function");
  a_timer_no_pin: assert property (sh_r.c1.mode_select == stc_pkg::MODE_TIMER
    && sh_r.quiet >= 3'h4 |-> !timer_output_pin_oe && !timer_output_pin)
    else $error("pin used in timer mode");
  a_p_blocked: assert property (sh_r.c1.clear_source_select
    && sh_r.c1.mode_select[1] == sh_r.c1.mode_select[0] && sh_r.quiet >= 3'h4
    |-> !$rose(match_p_flag)) else $error("flag p raised with clear on a");
  c_flag_a: cover property ($rose(match_a_flag));
  c_flag_p: cover property ($rose(match_p_flag));
  c_start: cover property (start);
endmodule // stc_timer_chk

bind stc_timer stc_timer_chk u_chk (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer_output_pin,
  .timer_output_pin_oe, .match_a_flag, .match_p_flag);
